/* core/swcfg_pkg.sv */
`default_nettype none
package swcfg_pkg;
	// frame layout
	localparam int FRAME_BITS  = 24;
	localparam int CMD_MSB     = 23;
	localparam int CMD_LSB     = 16;
	localparam int NUM_PROG    = 8;
	localparam int NUM_GND     = 14;
	localparam int NUM_INPUTS  = 22;
	localparam int CNT_W       = 5;
	// command bytes
	localparam logic [7:0] CMD_WAKE_PROG  = 8'h02;
	localparam logic [7:0] CMD_WAKE_GND   = 8'h03;
	localparam logic [7:0] CMD_LEVEL_PROG = 8'h04;
	localparam logic [7:0] CMD_LEVEL_GND  = 8'h05;
	localparam logic [7:0] CMD_ANALOG     = 8'h06;
	localparam logic [7:0] CMD_TIMER_PROG = 8'h07;
	localparam logic [7:0] CMD_TIMER_GND  = 8'h08;
	localparam logic [7:0] CMD_HIZ_PROG   = 8'h09;
	localparam logic [7:0] CMD_HIZ_GND    = 8'h0A;
	localparam logic [7:0] CMD_CALIBRATE  = 8'h0B;
	// analog field positions and codes
	localparam int ANA_CUR_MSB = 6;
	localparam int ANA_CUR_LSB = 5;
	localparam int ANA_CH_MSB  = 4;
	localparam int ANA_W       = 7;
	localparam logic [1:0] CUR_HIZ  = 2'h0;
	localparam logic [1:0] CUR_LOW  = 2'h1;
	localparam logic [1:0] CUR_HIGH = 2'h2;
	localparam logic [4:0] CH_NONE     = 5'h00;
	localparam logic [4:0] CH_GND_BASE = 5'h01;
	localparam logic [4:0] CH_GND_LAST = 5'h0E;
	localparam logic [4:0] CH_PRG_BASE = 5'h0F;
	localparam logic [4:0] CH_PRG_LAST = 5'h16;
	// power-on values
	localparam logic [NUM_INPUTS-1:0] RST_ALL_ONE = 22'h3FFFFF;
	localparam logic [ANA_W-1:0]      RST_ANALOG  = 7'h00;
	// timing
	localparam int CLK_HZ        = 25000000;
	localparam int WET_TIME_MS   = 20;
	localparam int WET_CYCLES    = (CLK_HZ / 1000) * WET_TIME_MS;
	localparam int CAL_TIME_US   = 512;
	localparam int CAL_CYCLES    = (CLK_HZ / 1000000) * CAL_TIME_US;
	localparam int TMR_W         = 24;
	// states
	typedef enum logic [1:0] {
		SWCFG_IDLE    = 2'b00,
		SWCFG_ARMED   = 2'b01,
		SWCFG_MEASURE = 2'b10
	} swcfg_cal_t;
endpackage
`default_nettype wire

/* core/swcfg_core.sv */
// Operation
// RULE1 - enable bit 1 lets input change assert interrupt/wake; 0 blocks both
// RULE2 - wake enables: command 0x02 prog bits 7:0, 0x03 ground bits 13:0
// RULE3 - level bit 1 selects 16 mA, 0 selects 2.0 mA
// RULE4 - level bits: command 0x04 prog, 0x05 ground
// RULE5 - per-input timer starts at threshold crossing; after 20 ms current drops
// RULE6 - timer disabled keeps 16 mA on closed input indefinitely
// RULE7 - timer bit 1 enables timed reduction, 0 disables it
// RULE8 - timer bits: command 0x07 prog, 0x08 ground
// RULE9 - tri-state bit 1 makes input high impedance; comparator stays active
// RULE10 - tri-state bits: command 0x09 prog, 0x0A ground
// RULE11 - analog bits 4:0 select none, ground inputs 0-13, prog inputs 0-7
// RULE12 - current bits 6:5: 00 hiz, 01 2 mA, 10 16 mA, 11 hiz
// RULE13 - selected analog input reports status 0 in next response frame
// RULE14 - analog command currents are always pull-ups
// RULE15 - analog frame: 0x06 in 23:16, 15:7 ignored, 6:0 fields
// RULE16 - after calibration command, measure 512 us chip-select low pulse
// RULE17 - master keeps other lines static during calibration pulse
// RULE18 - master should recalibrate periodically for drift
// RULE19 - calibration command byte 0x0B, other bits ignored
// RULE20 - registers update at any moment in normal mode
// RULE21 - every transaction is exactly 24 bits, status out while command in
// RULE22 - programming only in normal mode with interface supply present
// RULE23 - command decoded and applied at chip-select rise after full frame
`default_nettype none
module swcfg_core
	import swcfg_pkg::*;
#(
	parameter int WET_CYC = WET_CYCLES,
	parameter int CAL_CYC = CAL_CYCLES
) (
	// system
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	// serial link, sclk is its own domain
	input  wire logic                  sclk,
	input  wire logic                  cs_n,
	input  wire logic                  si,
	output logic                       so,
	output logic                       so_oe,
	// mode and supply
	input  wire logic                  normal_mode,
	input  wire logic                  vdd_ok,
	// comparator results, 1 = closed, ground inputs low bits
	input  wire logic [NUM_INPUTS-1:0] input_closed,
	input  wire logic                  therm_flag,
	// contact drive
	output logic [NUM_INPUTS-1:0]      wet_high,
	output logic [NUM_INPUTS-1:0]      input_hiz,
	output logic [NUM_INPUTS-1:0]      change_enable,
	// analog mux
	output logic [CNT_W-1:0]           analog_mux_channel,
	output logic [1:0]                 analog_mux_current,
	output logic                       analog_mux_pullup,
	// interrupt and calibration
	output logic                       int_n,
	output logic                       wake_request,
	output logic [TMR_W-1:0]           cal_cycles,
	output logic                       cal_done
);
	import swcfg_pkg::*;

	if (WET_CYC < 1 || WET_CYC >= (1 << TMR_W) || CAL_CYC < 1 || CAL_CYC >= (1 << TMR_W)) begin : g_bad_timing
		$error("swcfg_core: timing parameters out of range");
	end

	function automatic logic [NUM_INPUTS-1:0] merge(input logic [NUM_INPUTS-1:0] cur,
		input logic [7:0] cmd, input logic [FRAME_BITS-1:0] fr, input logic [7:0] cp, input logic [7:0] cg);
		logic [NUM_INPUTS-1:0] r;
		r = cur;
		if (cmd == cp)
			r[NUM_INPUTS-1:NUM_GND] = fr[NUM_PROG-1:0];
		else if (cmd == cg)
			r[NUM_GND-1:0] = fr[NUM_GND-1:0];
		return r;
	endfunction

	// ---- link domain: shift register clocked by sclk, frame framed by cs_n
	logic [FRAME_BITS-1:0] sh_in;
	logic [FRAME_BITS-1:0] sh_out;
	logic [CNT_W-1:0]      bit_cnt;
	logic [FRAME_BITS-1:0] resp_word;
	logic                  first_fall;
	logic                  frame_tog;
	// response is captured in the core domain; the first bit must stand before the first rising edge
	assign so    = first_fall ? resp_word[FRAME_BITS-1] : sh_out[FRAME_BITS-1];
	assign so_oe = ~cs_n;
	// count and data outlive cs_n so the core can read them; saturating at all ones keeps long frames out
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt   <= '0;
			sh_in     <= '0;
			frame_tog <= 1'b0;
		end else begin
			sh_in     <= {sh_in[FRAME_BITS-2:0], si};
			bit_cnt   <= first_fall ? CNT_W'(1) : ((bit_cnt == '1) ? bit_cnt : bit_cnt + 1'b1); // RULE21
			frame_tog <= first_fall ? ~frame_tog : frame_tog; // first_fall still stands at the first rise
		end
	end
	// shift out on falling edge, first bit driven straight from resp_word until the first sclk fall
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			first_fall <= 1'b1;
			sh_out     <= '0;
		end else begin
			first_fall <= 1'b0;
			sh_out     <= first_fall ? {resp_word[FRAME_BITS-2:0], 1'b0} : {sh_out[FRAME_BITS-2:0], 1'b0};
		end
	end

	// ---- core domain synchronisers
	logic [1:0] cs_sync;
	logic [1:0] tog_sync;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_sync  <= 2'h3;
			tog_sync <= 2'h0;
		end else begin
			cs_sync  <= {cs_sync[0], cs_n};
			tog_sync <= {tog_sync[0], frame_tog};
		end
	end
	logic cs_q;
	logic tog_seen;
	logic [NUM_INPUTS-1:0] cl_s1;
	logic [NUM_INPUTS-1:0] cl_s2;
	logic [NUM_INPUTS-1:0] cl_s3;
	// only the second stage and later are read, so edges never see a metastable value
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_q     <= 1'b1;
			tog_seen <= 1'b0;
			cl_s1    <= '0;
			cl_s2    <= '0;
			cl_s3    <= '0;
		end else begin
			cs_q     <= cs_sync[1];
			tog_seen <= (cs_sync[1] & ~cs_q) ? tog_sync[1] : tog_seen;
			cl_s1    <= input_closed;
			cl_s2    <= cl_s1;
			cl_s3    <= cl_s2;
		end
	end
	wire cs_rise = cs_sync[1] & ~cs_q;
	wire cs_fall = ~cs_sync[1] & cs_q;
	// count is stable once cs_n is high; a bare cs_n pulse has no clock and must not replay the last frame
	wire frame_ok = (bit_cnt == CNT_W'(FRAME_BITS)) & (tog_sync[1] ^ tog_seen); // RULE21
	wire [7:0] cmd = sh_in[CMD_MSB:CMD_LSB];
	wire apply = cs_rise & frame_ok & normal_mode & vdd_ok; // RULE22 RULE23

	// ---- configuration registers
	logic [NUM_INPUTS-1:0] wake_en, next_wake_en;
	logic [NUM_INPUTS-1:0] level, next_level;
	logic [NUM_INPUTS-1:0] tmr_en, next_tmr_en;
	logic [NUM_INPUTS-1:0] hiz, next_hiz;
	logic [ANA_W-1:0]      ana, next_ana;
	logic                  cal_cmd;
	// decode at chip-select rise, any moment in normal mode
	always_comb begin
		next_wake_en = wake_en;
		next_level   = level;
		next_tmr_en  = tmr_en;
		next_hiz     = hiz;
		next_ana     = ana;
		cal_cmd      = 1'b0;
		if (apply) begin // RULE20
			next_wake_en = merge(wake_en, cmd, sh_in, CMD_WAKE_PROG, CMD_WAKE_GND); // RULE2
			next_level   = merge(level, cmd, sh_in, CMD_LEVEL_PROG, CMD_LEVEL_GND); // RULE4
			next_tmr_en  = merge(tmr_en, cmd, sh_in, CMD_TIMER_PROG, CMD_TIMER_GND); // RULE8
			next_hiz     = merge(hiz, cmd, sh_in, CMD_HIZ_PROG, CMD_HIZ_GND); // RULE10
			if (cmd == CMD_ANALOG)
				next_ana = sh_in[ANA_W-1:0]; // RULE15
			cal_cmd = (cmd == CMD_CALIBRATE); // RULE19
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_en <= RST_ALL_ONE;
			level   <= RST_ALL_ONE;
			tmr_en  <= RST_ALL_ONE;
			hiz     <= RST_ALL_ONE;
			ana     <= RST_ANALOG;
		end else begin
			wake_en <= next_wake_en;
			level   <= next_level;
			tmr_en  <= next_tmr_en;
			hiz     <= next_hiz;
			ana     <= next_ana;
		end
	end

	// ---- per-input wetting timers, loaded at each comparator crossing
	logic [TMR_W-1:0] wtmr [NUM_INPUTS];
	logic [TMR_W-1:0] next_wtmr [NUM_INPUTS];
	logic [NUM_INPUTS-1:0] expired, next_expired;
	always_comb begin
		for (int i = 0; i < NUM_INPUTS; i++) begin
			next_wtmr[i]    = wtmr[i];
			next_expired[i] = expired[i];
			if (cl_s3[i] != cl_s2[i]) begin // RULE5
				next_wtmr[i]    = TMR_W'(WET_CYC);
				next_expired[i] = 1'b0;
			end else if (wtmr[i] != '0) begin
				next_wtmr[i]    = wtmr[i] - 1'b1;
				next_expired[i] = (wtmr[i] == TMR_W'(1));
			end
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_INPUTS; i++)
				wtmr[i] <= '0;
			expired <= '0;
		end else begin
			wtmr    <= next_wtmr;
			expired <= next_expired;
		end
	end
	// drive: timer only cuts current when enabled; tri-state overrides level
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wet_high      <= '0;
			input_hiz     <= RST_ALL_ONE;
			change_enable <= RST_ALL_ONE;
		end else begin
			wet_high      <= level & ~hiz & ~(tmr_en & expired); // RULE3 RULE5 RULE6 RULE7 RULE9
			input_hiz     <= hiz; // RULE9
			change_enable <= wake_en; // RULE1
		end
	end

	// ---- analog mux decode
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			analog_mux_channel <= CH_NONE;
			analog_mux_current <= CUR_HIZ;
			analog_mux_pullup  <= 1'b1;
		end else begin
			analog_mux_channel <= (ana[ANA_CH_MSB:0] > CH_PRG_LAST) ? CH_NONE : ana[ANA_CH_MSB:0]; // RULE11
			analog_mux_current <= (ana[ANA_CUR_MSB:ANA_CUR_LSB] == CUR_HIGH ||
				ana[ANA_CUR_MSB:ANA_CUR_LSB] == CUR_LOW) ? ana[ANA_CUR_MSB:ANA_CUR_LSB] : CUR_HIZ; // RULE12
			analog_mux_pullup  <= 1'b1; // RULE14
		end
	end
	// mask of the input feeding the mux
	logic [NUM_INPUTS-1:0] ana_mask;
	always_comb begin
		ana_mask = '0;
		for (int i = 0; i < NUM_INPUTS; i++)
			if (analog_mux_channel == CNT_W'(i + 1))
				ana_mask[i] = 1'b1;
	end

	// ---- interrupt and response latch
	logic int_pend, next_int_pend;
	logic mid_close, next_mid_close;
	logic [FRAME_BITS-1:0] next_resp;
	wire [NUM_INPUTS-1:0] change = (cl_s3 ^ cl_s2) & wake_en; // RULE1
	always_comb begin
		next_int_pend  = int_pend | (|change);
		next_mid_close = mid_close;
		next_resp      = resp_word;
		if (cs_fall) begin
			next_resp   = {therm_flag, int_pend, cl_s2 & ~ana_mask}; // RULE13
			next_mid_close = 1'b0;
		end
		if (~cs_sync[1] && |(change & cl_s2))
			next_mid_close = 1'b1;
		// a switch closing mid-frame keeps the interrupt; set wins over clear
		if (cs_rise && !mid_close && !(|change))
			next_int_pend = 1'b0;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_pend  <= 1'b0;
			mid_close <= 1'b0;
			resp_word <= '0;
		end else begin
			int_pend  <= next_int_pend;
			mid_close <= next_mid_close;
			resp_word <= next_resp;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_n        <= 1'b1;
			wake_request <= 1'b0;
		end else begin
			int_n        <= ~(int_pend & normal_mode); // RULE1
			wake_request <= int_pend & ~normal_mode; // RULE1
		end
	end

	// ---- calibration: measure the next chip-select low pulse
	swcfg_cal_t cal_st, next_cal_st;
	logic [TMR_W-1:0] cal_cnt, next_cal_cnt;
	logic [TMR_W-1:0] next_cal_cycles;
	logic next_cal_done;
	always_comb begin
		next_cal_st     = cal_st;
		next_cal_cnt    = cal_cnt;
		next_cal_cycles = cal_cycles;
		next_cal_done   = 1'b0;
		case (cal_st)
			SWCFG_IDLE: begin
				if (cal_cmd)
					next_cal_st = SWCFG_ARMED; // RULE16
			end
			SWCFG_ARMED: begin
				if (cs_fall) begin
					next_cal_st  = SWCFG_MEASURE;
					next_cal_cnt = TMR_W'(1);
				end
			end
			SWCFG_MEASURE: begin
				// other lines are assumed quiet, so no frame data is used here
				if (cs_rise) begin // RULE17
					next_cal_st     = SWCFG_IDLE;
					next_cal_cycles = cal_cnt; // RULE16
					next_cal_done   = 1'b1;
				end else if (cal_cnt != '1) begin
					next_cal_cnt = cal_cnt + 1'b1;
				end
			end
			default: next_cal_st = SWCFG_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_st     <= SWCFG_IDLE;
			cal_cnt    <= '0;
			cal_cycles <= TMR_W'(CAL_CYC);
			cal_done   <= 1'b0;
		end else begin
			cal_st     <= next_cal_st;
			cal_cnt    <= next_cal_cnt;
			cal_cycles <= next_cal_cycles;
			cal_done   <= next_cal_done;
		end
	end

	// ---- assertions
	property p_apply_wake;
		@(posedge ref_clk) disable iff (!rst_n)
		(apply && cmd == CMD_WAKE_PROG) |=> (wake_en[NUM_INPUTS-1:NUM_GND] == $past(sh_in[NUM_PROG-1:0])) ##1
			(change_enable[NUM_INPUTS-1:NUM_GND] == $past(sh_in[NUM_PROG-1:0], 2));
	endproperty
	a_apply_wake: assert property (p_apply_wake) else $error("wake enable not applied"); // RULE2
	property p_level_gnd;
		@(posedge ref_clk) disable iff (!rst_n)
		(apply && cmd == CMD_LEVEL_GND) |=> (level[NUM_GND-1:0] == $past(sh_in[NUM_GND-1:0]));
	endproperty
	a_level_gnd: assert property (p_level_gnd) else $error("level ground not applied"); // RULE4
	property p_hiz_cuts;
		@(posedge ref_clk) disable iff (!rst_n)
		(|hiz) |=> ((wet_high & $past(hiz)) == '0);
	endproperty
	a_hiz_cuts: assert property (p_hiz_cuts) else $error("hiz input still wetted"); // RULE9
	property p_timer_off;
		@(posedge ref_clk) disable iff (!rst_n)
		(tmr_en[0] == 1'b0 && level[0] && !hiz[0]) |=> wet_high[0];
	endproperty
	a_timer_off: assert property (p_timer_off) else $error("current cut without timer"); // RULE6
	property p_no_apply_sleep;
		@(posedge ref_clk) disable iff (!rst_n)
		(cs_rise && !normal_mode) |=> $stable(wake_en) && $stable(ana);
	endproperty
	a_no_apply_sleep: assert property (p_no_apply_sleep) else $error("write outside normal mode"); // RULE22
	property p_short_frame;
		@(posedge ref_clk) disable iff (!rst_n)
		(cs_rise && !frame_ok) |=> $stable(level) && $stable(tmr_en);
	endproperty
	a_short_frame: assert property (p_short_frame) else $error("short frame applied"); // RULE21
	property p_ana_cur;
		@(posedge ref_clk) disable iff (!rst_n)
		(ana[ANA_CUR_MSB:ANA_CUR_LSB] == 2'h3) |=> (analog_mux_current == CUR_HIZ);
	endproperty
	a_ana_cur: assert property (p_ana_cur) else $error("illegal current not hiz"); // RULE12
	property p_ana_mask;
		@(posedge ref_clk) disable iff (!rst_n)
		cs_fall |=> ((resp_word[NUM_INPUTS-1:0] & ana_mask) == '0);
	endproperty
	a_ana_mask: assert property (p_ana_mask) else $error("analog input status not zero"); // RULE13
	property p_cal_arm;
		@(posedge ref_clk) disable iff (!rst_n)
		cal_cmd |=> (cal_st == SWCFG_ARMED);
	endproperty
	a_cal_arm: assert property (p_cal_arm) else $error("calibration not armed"); // RULE16
	c_cal: cover property (@(posedge ref_clk) disable iff (!rst_n) cal_done);
	c_analog: cover property (@(posedge ref_clk) disable iff (!rst_n) apply && cmd == CMD_ANALOG);
	c_int: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(int_n));
endmodule
`default_nettype wire

/* verif/swcfg_mcu_model.sv */
`default_nettype none
// serial master stand-in; sclk idles low and only toggles inside a frame
module swcfg_mcu_model (
	// serial link
	output logic     sclk,
	output logic     cs_n,
	output logic     si,
	input  wire logic so
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [23:0] resp;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b0;
		si   = 1'b0;
		resp = 24'h000000;
		#1 cs_n = 1'b1;  // a clean rising edge after time zero presets the link-side flops
	end

	// one frame msb first; fewer than 24 bits gives a frame the device must drop
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] data, input int nbits);
		logic [23:0] frame;
		frame = {cmd, data};
		cs_n = 1'b0;
		#133;  // response is latched at the fall, give it three core cycles
		for (int i = 0; i < nbits; i++) begin
			si = frame[23 - i];
			#24;
			resp = {resp[22:0], so};  // taken before the rising edge, so has stood since the last fall
			sclk = 1'b1;
			#24 sclk = 1'b0;
		end
		#24 cs_n = 1'b1;
		si = ~si;  // released line shows no stale bit
		#400;  // gap covers apply latency and minimum high time
	endtask

	// low pulse for time-base calibration, other lines left untouched
	task automatic cal_pulse(input int ns_low);
		cs_n = 1'b0;
		#ns_low;
		cs_n = 1'b1;
	endtask
endmodule
`default_nettype wire

/* verif/swcfg_core_tb.sv */
`default_nettype none
module swcfg_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import swcfg_pkg::*;

	localparam logic [7:0]  WR_CMD [5] = '{8'h02, 8'h03, 8'h09, 8'h0A, 8'h09};
	localparam logic [15:0] WR_DAT [5] = '{16'hFF5A, 16'hEA5C, 16'h00C3, 16'h0000, 16'h0000};
	localparam logic [4:0]  ANA_CH [6] = '{5'h00, 5'h01, 5'h0E, 5'h0F, 5'h16, 5'h17};

	logic                  ref_clk, rst_n, normal_mode, vdd_ok, therm_flag;
	logic                  sclk, cs_n, si, so, so_oe;
	logic [NUM_INPUTS-1:0] input_closed, wet_high, input_hiz, change_enable;
	logic [CNT_W-1:0]      analog_mux_channel;
	logic [1:0]            analog_mux_current, cur;
	logic                  analog_mux_pullup, int_n, wake_request, cal_done, gnd;
	logic [TMR_W-1:0]      cal_cycles;
	logic [NUM_INPUTS-1:0] exp_wake, exp_hiz, e;
	int                    failures, tests_run, n;

	// short wetting count so the timed drop fits the run
	swcfg_core #(.WET_CYC(200), .CAL_CYC(12800)) DUT (
		.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
		.so(so), .so_oe(so_oe), .normal_mode(normal_mode), .vdd_ok(vdd_ok),
		.input_closed(input_closed), .therm_flag(therm_flag), .wet_high(wet_high),
		.input_hiz(input_hiz), .change_enable(change_enable),
		.analog_mux_channel(analog_mux_channel), .analog_mux_current(analog_mux_current),
		.analog_mux_pullup(analog_mux_pullup), .int_n(int_n), .wake_request(wake_request),
		.cal_cycles(cal_cycles), .cal_done(cal_done)
	);

	swcfg_mcu_model u_mcu (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

	// core clock, 40 ns
	initial ref_clk = 1'b0;
	always #20 ref_clk = ~ref_clk;

	task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic clks(input int k);
		repeat (k) @(negedge ref_clk);
	endtask

	// watchdog: the tests need about 1.1 ms
	initial begin
		#3000000;
		failures++;
		$display("FAIL %0t watchdog expired", $time);
		conclude();
	end

	initial begin
		rst_n = 1'b0;
		normal_mode = 1'b1;
		vdd_ok = 1'b1;
		therm_flag = 1'b0;
		input_closed = '0;
		failures = 0;
		tests_run = 0;
		exp_wake = RST_ALL_ONE;
		exp_hiz = RST_ALL_ONE;
		clks(10);
		rst_n = 1'b1;
		clks(4);
		check({2'h0, change_enable}, {2'h0, exp_wake}, "wake rst");
		check({2'h0, input_hiz}, {2'h0, exp_hiz}, "hiz rst");
		check({17'h0, analog_mux_channel, analog_mux_current}, 24'h000000, "ana rst");
		$display("test reset done");

		// wake and tri-state writes, upper bits of each frame must be ignored
		for (int i = 0; i < 5; i++) begin
			u_mcu.xfer(WR_CMD[i], WR_DAT[i], 24);
			gnd = (WR_CMD[i] == CMD_WAKE_GND) || (WR_CMD[i] == CMD_HIZ_GND);
			e = (WR_CMD[i] < CMD_LEVEL_PROG) ? exp_wake : exp_hiz;
			if (gnd) e[13:0] = WR_DAT[i][13:0];
			else e[21:14] = WR_DAT[i][7:0];
			if (WR_CMD[i] < CMD_LEVEL_PROG) exp_wake = e;
			else exp_hiz = e;
			check({2'h0, change_enable}, {2'h0, exp_wake}, "wake");
			check({2'h0, input_hiz}, {2'h0, exp_hiz}, "hiz");
		end
		$display("test writes done");

		// short frame, sleep mode, no supply, unknown command: all dropped
		for (int k = 0; k < 4; k++) begin
			@(negedge ref_clk);
			normal_mode = (k != 1);
			vdd_ok = (k != 2);
			u_mcu.xfer((k == 3) ? 8'h22 : CMD_WAKE_PROG, 16'h0000, (k == 0) ? 23 : 24);
			@(negedge ref_clk);
			normal_mode = 1'b1;
			vdd_ok = 1'b1;
			check({2'h0, change_enable}, {2'h0, exp_wake}, "refused");
		end
		$display("test refused done");

		// level with timers off, then timed drop on the programmable inputs
		u_mcu.xfer(CMD_TIMER_PROG, 16'h0000, 24);
		u_mcu.xfer(CMD_TIMER_GND, 16'h0000, 24);
		u_mcu.xfer(CMD_LEVEL_PROG, 16'h00A5, 24);
		u_mcu.xfer(CMD_LEVEL_GND, 16'h1234, 24);
		check({2'h0, wet_high}, {2'h0, 8'hA5, 14'h1234}, "level");
		u_mcu.xfer(CMD_LEVEL_PROG, 16'h00FF, 24);
		u_mcu.xfer(CMD_LEVEL_GND, 16'h3FFF, 24);
		u_mcu.xfer(CMD_TIMER_PROG, 16'h00FF, 24);
		clks(1);
		input_closed = '1;
		clks(100);
		check({2'h0, wet_high}, 24'h3FFFFF, "wet early");
		clks(160);
		check({2'h0, wet_high}, {2'h0, 8'h00, 14'h3FFF}, "wet late");
		$display("test wetting done");

		// every current code, channel ends and one code past the last
		for (int i = 0; i < 6; i++) begin
			cur = i[1:0];
			u_mcu.xfer(CMD_ANALOG, {9'h1FF, cur, ANA_CH[i]}, 24);
			check({16'h0, analog_mux_channel, analog_mux_current, analog_mux_pullup},
				{16'h0, (ANA_CH[i] > CH_PRG_LAST) ? CH_NONE : ANA_CH[i],
				(cur == 2'h3) ? CUR_HIZ : cur, 1'b1}, "analog");
		end
		$display("test analog done");

		// masked change leaves the line high, enabled change pulls it low
		u_mcu.xfer(CMD_WAKE_PROG, 16'h0000, 24);
		u_mcu.xfer(CMD_WAKE_GND, 16'h0000, 24);
		clks(1);
		input_closed[0] = 1'b0;
		clks(10);
		check({23'h0, int_n}, 24'h000001, "int masked");
		u_mcu.xfer(CMD_WAKE_GND, 16'h0001, 24);
		clks(1);
		input_closed[0] = 1'b1;
		clks(10);
		check({23'h0, int_n}, 24'h000000, "int set");
		u_mcu.xfer(8'h00, 16'h0000, 24);
		check({23'h0, int_n}, 24'h000001, "int clear");
		check(u_mcu.resp, 24'h7FFFFF, "status resp");
		// thermal flag in the top bit, analog channel on ground input 0 masks bit 0 of the next frame
		clks(1);
		therm_flag = 1'b1;
		u_mcu.xfer(CMD_ANALOG, 16'h0001, 24);
		u_mcu.xfer(8'h00, 16'h0000, 24);
		check(u_mcu.resp, 24'hBFFFFE, "masked resp");
		$display("test interrupt done");

		// calibrate twice, as drift calls for repeated runs
		repeat (2) begin
			u_mcu.xfer(CMD_CALIBRATE, 16'hFFFF, 24);
			u_mcu.cal_pulse(512000);
			n = 0;
			while (cal_done !== 1'b1 && n < 20) begin
				@(negedge ref_clk);
				n++;
			end
			check({23'h0, cal_done}, 24'h000001, "cal done");
			check({23'h0, (cal_cycles >= 24'h0031FD) && (cal_cycles <= 24'h003203)},
				24'h000001, "cal count");
			clks(10);
		end
		$display("test calibration done");
		conclude();
	end
endmodule
`default_nettype wire
